// ---- core/obt_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`default_nettype none

module obt_fifo #(
    parameter int unsigned W     = 9,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    obt_stream_if.snk in_s,
    obt_stream_if.src out_s
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push = in_s.valid & in_s.ready;
    assign pop  = out_s.valid & out_s.ready;

    // Storage written at the write index
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : obt_fifo

`default_nettype wire

// ---- core/obt_pkg.sv ----
// Constants shared by the registered bus transceiver and its helpers.
// Assumes a single sys_clk domain and a 32-bit classic Wishbone bus.
`default_nettype none

package obt_pkg;
    // Widths and depths
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned LOG_W     = DATA_W + 1;
    localparam int unsigned LOG_DEPTH = 8;
    localparam int unsigned PIN_W     = 2 * DATA_W + 6;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] LOG_OFS    = 4'h8;

    // Control field positions and reset value
    localparam int unsigned CTRL_SW_MODE = 0;
    localparam int unsigned CTRL_OE_N    = 1;
    localparam int unsigned CTRL_DIR     = 2;
    localparam int unsigned CTRL_AB_SEL  = 3;
    localparam int unsigned CTRL_BA_SEL  = 4;
    localparam logic [4:0]  CTRL_RST     = 5'h02;

    // Status field positions
    localparam int unsigned ST_AB_LSB   = 0;
    localparam int unsigned ST_BA_LSB   = 8;
    localparam int unsigned ST_DRIVE_A  = 16;
    localparam int unsigned ST_DRIVE_B  = 17;
    localparam int unsigned ST_EMPTY    = 18;
    localparam int unsigned ST_OVERFLOW = 19;

    // Capture log word layout
    localparam int unsigned LOG_DIR_BIT   = 8;
    localparam int unsigned LOG_VALID_BIT = 31;

    // Values after reset
    localparam logic [7:0] STORE_RST = 8'h00;
endpackage : obt_pkg

`default_nettype wire

// ---- core/obt_stream_if.sv ----
// Valid/ready stream carrier between the transceiver and its capture log.
// Assumes source and sink share one clock.
`default_nettype none

interface obt_stream_if #(
    parameter int unsigned W = 9
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : obt_stream_if

`default_nettype wire

// ---- core/obt_sync.sv ----
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a level that may change at any time.
`default_nettype none

module obt_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : obt_sync

`default_nettype wire

// ---- core/obt_transceiver.sv ----
// Octal registered bus transceiver with a Wishbone control/status port.
// Assumes all pins are asynchronous to sys_clk and are synchronised here;
// the two store clocks are sampled levels, not clock domains.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`default_nettype none

// Overview of operation
// [R01] Each store clock edge loads its port
// [R02] Capture ignores enable, direction and selects
// [R03] Enable high: both ports float, both loadable
// [R04] Direction low drives A, high drives B
// [R05] B-to-A select: live B or stored
// [R06] A-to-B select: live A or stored
// [R07] Driven port undefined during its store edge
// [R08] Both registers may capture in one cycle
// [R09] Disabled outputs still accept and store data
// [R10] Never drive both ports at once
// [R11] No edge, no change of stored data
// [R12] Reset clears stores and floats ports
module obt_transceiver (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Control pins
    input  wire logic        a_to_b_clock,
    input  wire logic        b_to_a_clock,
    input  wire logic        out_en_n,
    input  wire logic        dir,
    input  wire logic        a_to_b_source_select,
    input  wire logic        b_to_a_source_select,
    // Port A, three signals
    input  wire logic [7:0]  port_a_data_i,
    output logic      [7:0]  port_a_data_o,
    output logic             port_a_data_oe_n,
    // Port B, three signals
    input  wire logic [7:0]  port_b_data_i,
    output logic      [7:0]  port_b_data_o,
    output logic             port_b_data_oe_n
);
    localparam int unsigned DW = obt_pkg::DATA_W;

    // Synchronised pins
    logic [obt_pkg::PIN_W-1:0] pins_raw;
    logic [obt_pkg::PIN_W-1:0] pins_s;
    logic          ab_clk_s;
    logic          ba_clk_s;
    logic          oe_pin_s;
    logic          oe_n_pin_s;
    logic          dir_pin_s;
    logic          ab_sel_pin_s;
    logic          ba_sel_pin_s;
    logic [DW-1:0] a_in_s;
    logic [DW-1:0] b_in_s;

    // Edge detection and stores
    logic          ab_clk_prev_q;
    logic          ba_clk_prev_q;
    logic          ab_rise;
    logic          ba_rise;
    logic [DW-1:0] ab_store_q;
    logic [DW-1:0] ba_store_q;

    // Effective control
    logic [4:0]    ctrl_q;
    logic          oe_n_eff;
    logic          dir_eff;
    logic          ab_sel_eff;
    logic          ba_sel_eff;
    logic          drive_a;
    logic          drive_b;

    // Capture log
    logic          pend_ab_q;
    logic          pend_ba_q;
    logic [DW-1:0] pend_ab_data_q;
    logic [DW-1:0] pend_ba_data_q;
    logic          overflow_q;
    logic          push_ab;
    logic          push_ba;
    logic          log_pop;

    // Bus decode
    logic          wb_req;
    logic          wb_wr;
    logic          wb_rd;
    logic          ovf_clear;
    logic [31:0]   rd_data;

    obt_stream_if #(.W(obt_pkg::LOG_W)) log_in ();
    obt_stream_if #(.W(obt_pkg::LOG_W)) log_out ();

    // Write helper: true when a byte lane of the bit is enabled
    function automatic logic lane_on(input logic [3:0] sel,
                                     input int unsigned bit_pos);
        lane_on = sel[bit_pos / 8];
    endfunction : lane_on

    // Every pin passes two flops before any logic looks at it; the enable
    // goes through inverted so a cleared stage reads as disabled
    assign pins_raw = {a_to_b_clock, b_to_a_clock, ~out_en_n, dir,
                       a_to_b_source_select, b_to_a_source_select,
                       port_a_data_i, port_b_data_i};

    obt_sync #(.W(obt_pkg::PIN_W)) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign {ab_clk_s, ba_clk_s, oe_pin_s, dir_pin_s,
            ab_sel_pin_s, ba_sel_pin_s, a_in_s, b_in_s} = pins_s;
    assign oe_n_pin_s = ~oe_pin_s; // [R12]

    // Edge detectors work on the synchronised levels only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ab_clk_prev_q <= 1'b0;
            ba_clk_prev_q <= 1'b0;
        end else begin
            ab_clk_prev_q <= ab_clk_s;
            ba_clk_prev_q <= ba_clk_s;
        end
    end

    assign ab_rise = ab_clk_s & ~ab_clk_prev_q;
    assign ba_rise = ba_clk_s & ~ba_clk_prev_q;

    // Data and clock share the same sync delay, so the edge sees the
    // data that stood at the pin when the clock rose
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ab_store_q <= obt_pkg::STORE_RST; // [R12]
            ba_store_q <= obt_pkg::STORE_RST; // [R12]
        end else begin
            // No enable, direction or select term here   [R02] [R09]
            if (ab_rise) begin
                ab_store_q <= a_in_s; // [R01]
            end
            if (ba_rise) begin
                ba_store_q <= b_in_s; // [R01] [R08]
            end
        end // Otherwise both hold [R11]
    end

    // Software may take over the enable, direction and select pins; reset leaves pins in charge
    assign oe_n_eff   = ctrl_q[obt_pkg::CTRL_SW_MODE] ?
                        ctrl_q[obt_pkg::CTRL_OE_N] : oe_n_pin_s;
    assign dir_eff    = ctrl_q[obt_pkg::CTRL_SW_MODE] ?
                        ctrl_q[obt_pkg::CTRL_DIR] : dir_pin_s;
    assign ab_sel_eff = ctrl_q[obt_pkg::CTRL_SW_MODE] ?
                        ctrl_q[obt_pkg::CTRL_AB_SEL] : ab_sel_pin_s;
    assign ba_sel_eff = ctrl_q[obt_pkg::CTRL_SW_MODE] ?
                        ctrl_q[obt_pkg::CTRL_BA_SEL] : ba_sel_pin_s;

    // Direction picks exactly one port while enabled
    assign drive_a = ~oe_n_eff & ~dir_eff; // [R04] [R10]
    assign drive_b = ~oe_n_eff &  dir_eff; // [R04] [R10]

    // Port drivers; enable outputs are low while driving
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_a_data_oe_n <= 1'b1; // [R12]
            port_b_data_oe_n <= 1'b1; // [R12]
        end else begin
            port_a_data_oe_n <= ~drive_a; // [R03]
            port_b_data_oe_n <= ~drive_b; // [R03]
        end
    end

    // Output data follows the source select; a store edge may change the
    // stored value mid-stream, so the port is not stable across it [R07]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_a_data_o <= '0;
            port_b_data_o <= '0;
        end else begin
            port_a_data_o <= ba_sel_eff ? ba_store_q : b_in_s; // [R05]
            port_b_data_o <= ab_sel_eff ? ab_store_q : a_in_s; // [R06]
        end
    end

    // Each capture waits in a pending slot until the log accepts it or the next capture on the same side overwrites it,
    // so a full log stalls logging rather than the stores
    assign push_ab = pend_ab_q & log_in.ready;
    assign push_ba = pend_ba_q & log_in.ready & ~pend_ab_q;
    assign log_in.valid = pend_ab_q | pend_ba_q;
    assign log_in.data  = pend_ab_q ? {1'b0, pend_ab_data_q}
                                    : {1'b1, pend_ba_data_q};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_ab_q      <= 1'b0;
            pend_ba_q      <= 1'b0;
            pend_ab_data_q <= '0;
            pend_ba_data_q <= '0;
        end else begin
            if (ab_rise) begin
                pend_ab_q      <= 1'b1;
                pend_ab_data_q <= a_in_s;
            end else if (push_ab) begin
                pend_ab_q <= 1'b0;
            end
            if (ba_rise) begin
                pend_ba_q      <= 1'b1;
                pend_ba_data_q <= b_in_s;
            end else if (push_ba) begin
                pend_ba_q <= 1'b0;
            end
        end
    end

    // Overflow: a capture landed on a slot still waiting; set beats clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_q <= 1'b0;
        end else if ((ab_rise && pend_ab_q && !push_ab) ||
                     (ba_rise && pend_ba_q && !push_ba)) begin
            overflow_q <= 1'b1;
        end else if (ovf_clear) begin
            overflow_q <= 1'b0;
        end
    end

    obt_fifo #(.W(obt_pkg::LOG_W), .DEPTH(obt_pkg::LOG_DEPTH)) u_log (
        .sys_clk (sys_clk),
        .rst     (rst),
        .in_s    (log_in),
        .out_s   (log_out)
    );

    // Wishbone: one-cycle registered ack, dropped the cycle after
    assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr     = wb_req & wb_we_i;
    assign wb_rd     = wb_req & ~wb_we_i;
    assign log_pop   = wb_rd & (wb_adr_i == obt_pkg::LOG_OFS);
    assign ovf_clear = wb_wr & (wb_adr_i == obt_pkg::STATUS_OFS) &
                       lane_on(wb_sel_i, obt_pkg::ST_OVERFLOW) &
                       wb_dat_i[obt_pkg::ST_OVERFLOW];
    assign log_out.ready = log_pop;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Control register, byte lane 0 only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= obt_pkg::CTRL_RST;
        end else if (wb_wr && wb_adr_i == obt_pkg::CTRL_OFS &&
                     wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[4:0];
        end
    end

    // Read mux; unmapped offsets read zero and ignore writes
    always_comb begin
        rd_data = '0;
        unique case (wb_adr_i)
            obt_pkg::CTRL_OFS: begin
                rd_data[4:0] = ctrl_q;
            end
            obt_pkg::STATUS_OFS: begin
                rd_data[obt_pkg::ST_AB_LSB +: DW] = ab_store_q;
                rd_data[obt_pkg::ST_BA_LSB +: DW] = ba_store_q;
                rd_data[obt_pkg::ST_DRIVE_A]  = ~port_a_data_oe_n;
                rd_data[obt_pkg::ST_DRIVE_B]  = ~port_b_data_oe_n;
                rd_data[obt_pkg::ST_EMPTY]    = ~log_out.valid;
                rd_data[obt_pkg::ST_OVERFLOW] = overflow_q;
            end
            obt_pkg::LOG_OFS: begin
                rd_data[obt_pkg::LOG_W-1:0]     = log_out.data;
                rd_data[obt_pkg::LOG_VALID_BIT] = log_out.valid;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (wb_rd) begin
            wb_dat_o <= rd_data;
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence ab_edge_s;
        ab_clk_s && !ab_clk_prev_q;
    endsequence

    sequence ba_edge_s;
        ba_clk_s && !ba_clk_prev_q;
    endsequence

    store_ab_load_a: assert property ( // [R01]
        ab_edge_s |=> ab_store_q == $past(a_in_s))
        else $error("A-to-B store missed its edge");

    store_ba_load_a: assert property ( // [R08]
        ba_edge_s |=> ba_store_q == $past(b_in_s))
        else $error("B-to-A store missed its edge");

    capture_ungated_a: assert property ( // [R02]
        (oe_n_eff and ab_edge_s) |=> ab_store_q == $past(a_in_s))
        else $error("Capture gated by disabled outputs");

    store_hold_a: assert property ( // [R11]
        !ab_rise && !ba_rise |=> $stable(ab_store_q) && $stable(ba_store_q))
        else $error("Store changed without an edge");

    isolation_float_a: assert property ( // [R03]
        oe_n_eff |=> port_a_data_oe_n && port_b_data_oe_n)
        else $error("Port driven while disabled");

    single_drive_a: assert property ( // [R10]
        port_a_data_oe_n || port_b_data_oe_n)
        else $error("Both ports driven");

    dir_select_a: assert property ( // [R04]
        !oe_n_eff |=> (port_a_data_oe_n == $past(dir_eff)) &&
                      (port_b_data_oe_n != $past(dir_eff)))
        else $error("Wrong port driven for direction");

    a_source_a: assert property ( // [R05]
        drive_a ##0 ba_sel_eff |=> port_a_data_o == $past(ba_store_q))
        else $error("Port A not showing stored data");

    b_live_a: assert property ( // [R06]
        drive_b ##0 !ab_sel_eff ##1 1'b1 |-> port_b_data_o == $past(a_in_s))
        else $error("Port B not passing live data");

    reset_clear_a: assert property ( // [R12]
        @(posedge sys_clk) disable iff (1'b0)
        rst |=> ab_store_q == '0 && ba_store_q == '0 &&
                port_a_data_oe_n && port_b_data_oe_n)
        else $error("Reset left data or drive");

    bus_ack_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single pulse one cycle later");
endmodule : obt_transceiver

`default_nettype wire

// ---- verification/obt_bus_partner.sv ----
// Model of the two parallel buses and their drivers beside the transceiver.
// Assumes the bench sets the value and enable of each far-side driver.
`default_nettype none

module obt_bus_partner (
    input  wire logic       sys_clk,
    input  wire logic [7:0] a_drive,
    input  wire logic       a_en,
    input  wire logic [7:0] b_drive,
    input  wire logic       b_en,
    input  wire logic [7:0] dev_a_out,
    input  wire logic       dev_a_oe_n,
    input  wire logic [7:0] dev_b_out,
    input  wire logic       dev_b_oe_n,
    output logic      [7:0] wire_a,
    output logic      [7:0] wire_b
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] float_q = 8'h00;

    // A released bus shows a changing pattern, never its last value
    always_ff @(posedge sys_clk) begin
        float_q <= float_q + 8'h5b;
    end

    // Far side yields whenever the device drives that bus
    always_comb begin
        wire_a = !dev_a_oe_n ? dev_a_out : (a_en ? a_drive : float_q);
        wire_b = !dev_b_oe_n ? dev_b_out
                             : (b_en ? b_drive : ~float_q);
    end
endmodule : obt_bus_partner

`default_nettype wire

// ---- verification/obt_transceiver_tb_top.sv ----
// Self-checking bench for the registered bus transceiver.
// Assumes the bus partner model and the design files are compiled first.
`default_nettype none

module obt_transceiver_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd, rdat;
    logic        ack, ab_clk = 1'b0, ba_clk = 1'b0;
    logic        oe_n = 1'b1, dir = 1'b0, ab_sel = 1'b0, ba_sel = 1'b0;
    logic [7:0]  a_val = 8'h00, b_val = 8'h00, a_wire, b_wire, a_out, b_out;
    logic        a_en = 1'b1, b_en = 1'b1, a_oe_n, b_oe_n;
    int          fail_count = 0;
    int          check_count = 0;

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    obt_transceiver u_obt_transceiver (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .a_to_b_clock(ab_clk),
        .b_to_a_clock(ba_clk), .out_en_n(oe_n), .dir(dir),
        .a_to_b_source_select(ab_sel), .b_to_a_source_select(ba_sel),
        .port_a_data_i(a_wire), .port_a_data_o(a_out),
        .port_a_data_oe_n(a_oe_n), .port_b_data_i(b_wire),
        .port_b_data_o(b_out), .port_b_data_oe_n(b_oe_n));

    obt_bus_partner u_obt_bus_partner (
        .sys_clk(sys_clk), .a_drive(a_val), .a_en(a_en), .b_drive(b_val),
        .b_en(b_en), .dev_a_out(a_out), .dev_a_oe_n(a_oe_n),
        .dev_b_out(b_out), .dev_b_oe_n(b_oe_n), .wire_a(a_wire),
        .wire_b(b_wire));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; held until ack is sampled, bounded wait
    task automatic wb_cycle(input logic w, input logic [3:0] a,
                            input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            complete_run();
        end
    endtask : wb_cycle

    // Store clock pins held 3 cycles high and 3 low so the sync sees them
    task automatic pulse(input logic ab, input logic ba);
        @(posedge sys_clk);
        ab_clk <= ab;
        ba_clk <= ba;
        repeat (3) @(posedge sys_clk);
        ab_clk <= 1'b0;
        ba_clk <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse

    task automatic do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        // Ports must stay released while the pin syncs refill
        repeat (4) begin
            @(posedge sys_clk);
            chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
        end
        wb_cycle(1'b0, obt_pkg::CTRL_OFS, 32'h0, 4'hf);
        chk(rd, {27'h0, obt_pkg::CTRL_RST});
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk(rd, 32'h0004_0000);
        chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
    endtask : do_reset

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        do_reset();
        // Isolation: capture both sides at once, controls set to other values
        a_val  <= 8'h3c;
        b_val  <= 8'hc5;
        dir    <= 1'b1;
        ab_sel <= 1'b1;
        ba_sel <= 1'b1;
        pulse(1'b1, 1'b1);
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk({16'h0, rd[15:0]}, 32'h0000_c53c);
        chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
        a_val <= 8'h11;
        b_val <= 8'h22;
        repeat (12) @(posedge sys_clk);
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk({16'h0, rd[15:0]}, 32'h0000_c53c);
        // Capture log order and an unmapped place
        wb_cycle(1'b0, obt_pkg::LOG_OFS, 32'h0, 4'hf);
        chk(rd, 32'h8000_003c);
        wb_cycle(1'b0, obt_pkg::LOG_OFS, 32'h0, 4'hf);
        chk(rd, 32'h8000_01c5);
        wb_cycle(1'b0, obt_pkg::LOG_OFS, 32'h0, 4'hf);
        chk({31'h0, rd[31]}, 32'h0);
        wb_cycle(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
        wb_cycle(1'b0, 4'hc, 32'h0, 4'hf);
        chk(rd, 32'h0);
        // Enabled outputs: every direction and source choice
        a_val <= 8'h96;
        b_val <= 8'h69;
        oe_n  <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            dir    <= i[1];
            ab_sel <= i[0];
            ba_sel <= i[0];
            repeat (8) @(posedge sys_clk);
            wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
            if (i[1]) begin
                chk({30'h0, a_oe_n, b_oe_n}, 32'h2);
                chk({24'h0, b_out}, i[0] ? 32'h3c : 32'h96);
                chk({30'h0, rd[17:16]}, 32'h2);
            end else begin
                chk({30'h0, a_oe_n, b_oe_n}, 32'h1);
                chk({24'h0, a_out}, i[0] ? 32'hc5 : 32'h69);
                chk({30'h0, rd[17:16]}, 32'h1);
            end
        end
        // Software control replaces the pins
        oe_n <= 1'b1;
        wb_cycle(1'b1, obt_pkg::CTRL_OFS, 32'h0000_000d, 4'h1);
        repeat (4) @(posedge sys_clk);
        chk({30'h0, a_oe_n, b_oe_n}, 32'h2);
        chk({24'h0, b_out}, 32'h3c);
        wb_cycle(1'b1, obt_pkg::CTRL_OFS, 32'h0000_0003, 4'h1);
        repeat (4) @(posedge sys_clk);
        chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
        wb_cycle(1'b1, obt_pkg::CTRL_OFS, 32'h0000_0002, 4'h1);
        // Fill the log past its depth while nobody drains it
        for (int i = 0; i < 10; i++) begin
            a_val <= 8'(i);
            repeat (3) @(posedge sys_clk);
            pulse(1'b1, 1'b0);
        end
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk({12'h0, rd[19:18], rd[7:0], 10'h0}, 32'h0008_2400);
        wb_cycle(1'b1, obt_pkg::STATUS_OFS, 32'h0008_0000, 4'h4);
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk({31'h0, rd[19]}, 32'h0);
        // Drain: eight oldest, then the capture that overwrote the pending entry
        for (int i = 0; i < 9; i++) begin
            wb_cycle(1'b0, obt_pkg::LOG_OFS, 32'h0, 4'hf);
            chk(rd, 32'h8000_0000 | (i == 8 ? 32'h9 : 32'(i)));
        end
        wb_cycle(1'b0, obt_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk({31'h0, rd[18]}, 32'h1);
        // Reset in mid-run clears stores and floats both ports
        do_reset();
        complete_run();
    end
endmodule : obt_transceiver_tb_top

`default_nettype wire
